// file: src/esm_unit.sv
// Purpose: Exception vector and error code former, plus system management mode entry.
// Assumes: Core supplies one exception request per pulse and keeps header sources stable
//          from entry until the header is written.
// Notes:   Error code result is registered one cycle after the request.
`timescale 1ns/1ps

module esm_unit (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Exception request from core
  input wire logic EXC_REQ,
  input wire esm_pkg::esm_cause_t EXC_CAUSE,
  input wire logic REAL_MODE,
  input wire logic [12:0] EXC_SEL_INDEX,
  input wire logic EXC_SEL_TABLE_INDICATOR,
  input wire logic EXC_IN_HANDLER,
  input wire logic PF_PROT_VIOLATION,
  input wire logic PF_WRITE,
  input wire logic PF_USER,
  // Exception result
  output logic EXC_VALID,
  output logic EXC_DROPPED,
  output logic [7:0] EXC_VECTOR,
  output logic EXC_ERR_PUSH,
  output logic [15:0] EXC_ERR_CODE,
  // Management pin and triggers
  input wire logic SYSMGMT_IRQ_N,
  input wire logic SW_SYSMGMT_TRIGGER_INSTR,
  input wire logic MEM_REGION_TRIGGER,
  input wire logic RESUME_FROM_SYSMGMT,
  // Management configuration
  input wire logic [31:0] SYSMGMT_REGION_BASE,
  input wire logic [31:0] SYSMGMT_REGION_SIZE,
  input wire logic SYSMGMT_ACCESS_CTRL,
  input wire logic SYSMGMT_PIN_ENABLE,
  // Competing interrupts
  input wire logic NMI_REQ,
  output logic NMI_TAKE,
  // Saved state sources
  input wire logic [31:0] SAVE_DBG7,
  input wire logic [31:0] SAVE_EFLAGS,
  input wire logic [31:0] SAVE_CTRL0,
  input wire logic [31:0] SAVE_CUR_IP,
  input wire logic [31:0] SAVE_NEXT_IP,
  input wire logic [15:0] SAVE_CS_SEL,
  input wire logic [63:0] SAVE_CS_DESC,
  // Header write port
  output logic HDR_WE,
  output logic [31:0] HDR_ADDR,
  output logic [31:0] HDR_DATA,
  input wire logic HDR_READY,
  // Core control
  output logic FETCH_VALID,
  output logic [31:0] FETCH_ADDR,
  output logic FORCE_REAL_MODE,
  output logic SYSMGMT_MODE,
  output logic SYSMGMT_PENDING
);

  // ----------------------------------------------------------------
  // Error code helpers
  // ----------------------------------------------------------------
  // Segment form: index, table indicator, bit 1 clear, origin
  function automatic logic [15:0] seg_code(input logic [12:0] idx, input logic ti, input logic org);
    logic [15:0] c;
    c = esm_pkg::ERR_ZERO;
    c[esm_pkg::ERR_INDEX_LSB +: esm_pkg::ERR_INDEX_W] = idx;
    c[esm_pkg::ERR_CAUSE_POS] = ti;
    c[esm_pkg::ERR_ACCESS_POS] = 1'b0;
    c[esm_pkg::ERR_ORIGIN_POS] = org;
    return c;
  endfunction : seg_code

  // Descriptor table form: index, bit 1 set, origin
  function automatic logic [15:0] idt_code(input logic [12:0] idx, input logic org);
    logic [15:0] c;
    c = esm_pkg::ERR_ZERO;
    c[esm_pkg::ERR_INDEX_LSB +: esm_pkg::ERR_INDEX_W] = idx;
    c[esm_pkg::ERR_ACCESS_POS] = 1'b1;
    c[esm_pkg::ERR_ORIGIN_POS] = org;
    return c;
  endfunction : idt_code

  // Page form: index driven zero since it means nothing here
  function automatic logic [15:0] pf_code(input logic prot, input logic wr, input logic usr);
    logic [15:0] c;
    c = esm_pkg::ERR_ZERO;
    c[esm_pkg::ERR_CAUSE_POS] = prot;
    c[esm_pkg::ERR_ACCESS_POS] = wr;
    c[esm_pkg::ERR_ORIGIN_POS] = usr;
    return c;
  endfunction : pf_code

  // ----------------------------------------------------------------
  // Exception mapping
  // ----------------------------------------------------------------
  logic [7:0] vec_next;
  logic push_next;
  logic drop_next;
  logic [15:0] code_next;
  logic [15:0] seg_err;

  assign seg_err = seg_code(EXC_SEL_INDEX, EXC_SEL_TABLE_INDICATOR, EXC_IN_HANDLER);

  // Real mode collapses several causes; no code is ever pushed there
  always_comb begin
    vec_next = esm_pkg::VEC_GEN_PROT;
    push_next = 1'b0;
    drop_next = 1'b0;
    code_next = esm_pkg::ERR_ZERO;
    case (EXC_CAUSE)
      esm_pkg::CAUSE_DOUBLE: begin
        vec_next = esm_pkg::VEC_DOUBLE;
        push_next = ~REAL_MODE;
        code_next = esm_pkg::ERR_ZERO;
      end
      esm_pkg::CAUSE_ALIGN: begin
        vec_next = esm_pkg::VEC_ALIGN;
        push_next = ~REAL_MODE;
        code_next = esm_pkg::ERR_ZERO;
      end
      esm_pkg::CAUSE_IDT_LIMIT: begin
        if (REAL_MODE) begin
          vec_next = esm_pkg::VEC_DOUBLE;
        end else begin
          vec_next = esm_pkg::VEC_GEN_PROT;
          push_next = 1'b1;
          code_next = idt_code(EXC_SEL_INDEX, EXC_IN_HANDLER);
        end
      end
      esm_pkg::CAUSE_STACK_LIMIT: begin
        vec_next = esm_pkg::VEC_STACK;
        push_next = ~REAL_MODE;
        code_next = REAL_MODE ? esm_pkg::ERR_ZERO : seg_err;
      end
      esm_pkg::CAUSE_SEG_LIMIT, esm_pkg::CAUSE_GEN_PROT: begin
        vec_next = esm_pkg::VEC_GEN_PROT;
        push_next = ~REAL_MODE;
        code_next = REAL_MODE ? esm_pkg::ERR_ZERO : seg_err;
      end
      esm_pkg::CAUSE_BAD_TASK_SEG: begin
        vec_next = esm_pkg::VEC_BAD_TASK_SEG;
        drop_next = REAL_MODE;
        push_next = ~REAL_MODE;
        code_next = seg_err;
      end
      esm_pkg::CAUSE_NOT_PRESENT: begin
        vec_next = esm_pkg::VEC_NOT_PRESENT;
        drop_next = REAL_MODE;
        push_next = ~REAL_MODE;
        code_next = seg_err;
      end
      esm_pkg::CAUSE_PAGE: begin
        vec_next = esm_pkg::VEC_PAGE;
        drop_next = REAL_MODE;
        push_next = ~REAL_MODE;
        code_next = pf_code(PF_PROT_VIOLATION, PF_WRITE, PF_USER);
      end
      default: begin
        drop_next = 1'b1;
      end
    endcase
  end

  // Result pulses for one cycle; vector and code hold until next request
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXC_VALID <= 1'b0;
      EXC_DROPPED <= 1'b0;
      EXC_VECTOR <= esm_pkg::VEC_DOUBLE;
      EXC_ERR_PUSH <= 1'b0;
      EXC_ERR_CODE <= esm_pkg::ERR_ZERO;
    end else begin
      EXC_VALID <= EXC_REQ & ~drop_next;
      EXC_DROPPED <= EXC_REQ & drop_next;
      if (EXC_REQ) begin
        EXC_VECTOR <= vec_next;
        EXC_ERR_PUSH <= push_next & ~drop_next;
        EXC_ERR_CODE <= (push_next & ~drop_next) ? code_next : esm_pkg::ERR_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Management pin synchroniser
  // ----------------------------------------------------------------
  esm_pin_if pin_bus ();

  esm_pin_sync u_pin_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .PIN_N(SYSMGMT_IRQ_N),
    .pin(pin_bus.src)
  );

  // ----------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------
  logic region_set;
  logic pin_ok;
  logic sw_ok;
  logic pin_evt;
  logic resume_evt;
  logic any_evt;
  logic take;
  logic stayed_low_reg;
  logic pend_reg;
  esm_pkg::esm_state_t state_reg;

  // An unprogrammed region means nowhere to go, so nothing is recognised
  assign region_set = |SYSMGMT_REGION_SIZE;
  assign pin_ok = region_set & SYSMGMT_PIN_ENABLE;
  assign sw_ok = region_set & SYSMGMT_ACCESS_CTRL;
  assign pin_evt = pin_bus.dst.fall & pin_ok;
  // Pin still low at resume but released since last entry counts again
  assign resume_evt = (state_reg == esm_pkg::ST_ACTIVE) & RESUME_FROM_SYSMGMT & pin_ok
                      & pin_bus.dst.level_low & ~stayed_low_reg;
  // Pin, region and instruction collapse into one request
  assign any_evt = pin_evt | (MEM_REGION_TRIGGER & pin_ok)
                   | (SW_SYSMGMT_TRIGGER_INSTR & sw_ok)
                   | resume_evt;
  assign take = (state_reg == esm_pkg::ST_IDLE) & pend_reg;

  // Pending flag; a new event in the taking cycle survives
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_reg <= 1'b0;
    end else if (any_evt) begin
      pend_reg <= 1'b1;
    end else if (take) begin
      pend_reg <= 1'b0;
    end
  end

  // Tracks whether the pin stayed low since the last entry began
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stayed_low_reg <= 1'b0;
    end else if (!pin_bus.dst.level_low) begin
      stayed_low_reg <= 1'b0;
    end else if (take) begin
      stayed_low_reg <= 1'b1;
    end
  end

  // Management wins over NMI and holds it off while in the mode
  assign NMI_TAKE = NMI_REQ & (state_reg == esm_pkg::ST_IDLE) & ~pend_reg & ~any_evt;
  assign SYSMGMT_PENDING = pend_reg;

  // ----------------------------------------------------------------
  // Header word selection
  // ----------------------------------------------------------------
  logic [31:0] region_top;
  logic [2:0] idx_reg;

  assign region_top = SYSMGMT_REGION_BASE + SYSMGMT_REGION_SIZE;

  // Offset and data for each saved word
  function automatic logic [63:0] hdr_word(input logic [2:0] i, input logic [31:0] top);
    logic [31:0] ofs;
    logic [31:0] dat;
    ofs = esm_pkg::HDR_OFS_CS_LO;
    dat = SAVE_CS_DESC[31:0];
    case (i)
      3'h0: begin ofs = esm_pkg::HDR_OFS_DBG7; dat = SAVE_DBG7; end
      3'h1: begin ofs = esm_pkg::HDR_OFS_EFLAGS; dat = SAVE_EFLAGS; end
      3'h2: begin ofs = esm_pkg::HDR_OFS_CTRL0; dat = SAVE_CTRL0; end
      3'h3: begin ofs = esm_pkg::HDR_OFS_CUR_IP; dat = SAVE_CUR_IP; end
      3'h4: begin ofs = esm_pkg::HDR_OFS_NEXT_IP; dat = SAVE_NEXT_IP; end
      3'h5: begin ofs = esm_pkg::HDR_OFS_CS_SEL; dat = {16'h0000, SAVE_CS_SEL}; end
      3'h6: begin ofs = esm_pkg::HDR_OFS_CS_HI; dat = SAVE_CS_DESC[63:32]; end
      default: begin ofs = esm_pkg::HDR_OFS_CS_LO; dat = SAVE_CS_DESC[31:0]; end
    endcase
    return {top - ofs, dat};
  endfunction : hdr_word

  logic [63:0] first_word;
  logic [63:0] next_word;

  assign first_word = hdr_word(esm_pkg::HDR_IDX_RST, region_top);
  assign next_word = hdr_word(idx_reg + 3'h1, region_top);

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------
  // Header is written first, then real mode is forced and fetch redirected
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= esm_pkg::ST_IDLE;
      idx_reg <= esm_pkg::HDR_IDX_RST;
      HDR_WE <= 1'b0;
      HDR_ADDR <= 32'h0000_0000;
      HDR_DATA <= 32'h0000_0000;
    end else begin
      case (state_reg)
        esm_pkg::ST_IDLE: begin
          if (take) begin
            state_reg <= esm_pkg::ST_SAVE;
            idx_reg <= esm_pkg::HDR_IDX_RST;
            HDR_WE <= 1'b1;
            HDR_ADDR <= first_word[63:32];
            HDR_DATA <= first_word[31:0];
          end
        end
        esm_pkg::ST_SAVE: begin
          // Memory back-pressure holds the word in place
          if (HDR_READY) begin
            if (idx_reg == esm_pkg::HDR_LAST) begin
              HDR_WE <= 1'b0;
              state_reg <= esm_pkg::ST_ENTER;
            end else begin
              idx_reg <= idx_reg + 3'h1;
              HDR_ADDR <= next_word[63:32];
              HDR_DATA <= next_word[31:0];
            end
          end
        end
        esm_pkg::ST_ENTER: begin
          state_reg <= esm_pkg::ST_ACTIVE;
        end
        esm_pkg::ST_ACTIVE: begin
          if (RESUME_FROM_SYSMGMT) begin
            state_reg <= esm_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= esm_pkg::ST_IDLE;
          HDR_WE <= 1'b0;
        end
      endcase
    end
  end

  // Fetch redirect and mode outputs
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FETCH_VALID <= 1'b0;
      FETCH_ADDR <= 32'h0000_0000;
      FORCE_REAL_MODE <= 1'b0;
      SYSMGMT_MODE <= 1'b0;
    end else begin
      FETCH_VALID <= (state_reg == esm_pkg::ST_ENTER);
      if (state_reg == esm_pkg::ST_ENTER) begin
        FETCH_ADDR <= SYSMGMT_REGION_BASE;
        FORCE_REAL_MODE <= 1'b1;
        SYSMGMT_MODE <= 1'b1;
      end else if ((state_reg == esm_pkg::ST_ACTIVE) && RESUME_FROM_SYSMGMT) begin
        FORCE_REAL_MODE <= 1'b0;
        SYSMGMT_MODE <= 1'b0;
      end
    end
  end

endmodule : esm_unit

// file: src/esm_pkg.sv
// Purpose: Shared constants and types for the exception code and management entry unit.
// Assumes: 32-bit physical addresses and a 16-bit error code.
// Notes:   Header offsets are byte distances below the top of the management region.

package esm_pkg;

  // ----------------------------------------------------------------
  // Exception vectors
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_BAD_TASK_SEG = 8'h0a;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0b;
  localparam logic [7:0] VEC_STACK = 8'h0c;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0d;
  localparam logic [7:0] VEC_PAGE = 8'h0e;
  localparam logic [7:0] VEC_ALIGN = 8'h11;

  // ----------------------------------------------------------------
  // Error code layout
  // ----------------------------------------------------------------
  localparam int ERR_W = 16;
  localparam int ERR_INDEX_LSB = 3;
  localparam int ERR_INDEX_W = 13;
  localparam int ERR_CAUSE_POS = 2;
  localparam int ERR_ACCESS_POS = 1;
  localparam int ERR_ORIGIN_POS = 0;
  localparam logic [15:0] ERR_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Saved header layout
  // ----------------------------------------------------------------
  localparam int HDR_WORDS = 8;
  localparam logic [2:0] HDR_LAST = 3'h7;
  localparam logic [31:0] HDR_OFS_DBG7 = 32'h0000_0004;
  localparam logic [31:0] HDR_OFS_EFLAGS = 32'h0000_0008;
  localparam logic [31:0] HDR_OFS_CTRL0 = 32'h0000_000c;
  localparam logic [31:0] HDR_OFS_CUR_IP = 32'h0000_0010;
  localparam logic [31:0] HDR_OFS_NEXT_IP = 32'h0000_0014;
  localparam logic [31:0] HDR_OFS_CS_SEL = 32'h0000_0018;
  localparam logic [31:0] HDR_OFS_CS_HI = 32'h0000_001c;
  localparam logic [31:0] HDR_OFS_CS_LO = 32'h0000_0020;

  // ----------------------------------------------------------------
  // Reset values and pin idle level
  // ----------------------------------------------------------------
  localparam logic PIN_IDLE_LEVEL = 1'b1;
  localparam logic [2:0] HDR_IDX_RST = 3'h0;

  // Exception causes reported by the core
  typedef enum logic [3:0] {
    CAUSE_DOUBLE = 4'h0,
    CAUSE_ALIGN = 4'h1,
    CAUSE_IDT_LIMIT = 4'h2,
    CAUSE_STACK_LIMIT = 4'h3,
    CAUSE_SEG_LIMIT = 4'h4,
    CAUSE_BAD_TASK_SEG = 4'h5,
    CAUSE_NOT_PRESENT = 4'h6,
    CAUSE_GEN_PROT = 4'h7,
    CAUSE_PAGE = 4'h8
  } esm_cause_t;

  // Management entry sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAVE = 4'b0010,
    ST_ENTER = 4'b0100,
    ST_ACTIVE = 4'b1000
  } esm_state_t;

endpackage : esm_pkg

// file: src/esm_pin_if.sv
// Purpose: Carries the synchronised management pin from the synchroniser to the unit.
// Assumes: Both ends run on the system clock.
// Notes:   fall is a one-cycle pulse.
`timescale 1ns/1ps

interface esm_pin_if;
  logic level_low;
  logic fall;
  modport src (output level_low, output fall);
  modport dst (input level_low, input fall);
endinterface : esm_pin_if

// file: src/esm_pin_sync.sv
// Purpose: Two-stage synchroniser and falling edge detector for the management pin.
// Assumes: Pin is asynchronous to CLK and idles high.
// Notes:   Only the second stage and its delayed copy are examined by any logic.
`timescale 1ns/1ps

module esm_pin_sync (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Raw pin, active low
  input wire logic PIN_N,
  // Synchronised view
  esm_pin_if.src pin
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Reset to idle high so release never looks like an edge
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_reg <= esm_pkg::PIN_IDLE_LEVEL;
      sync_reg <= esm_pkg::PIN_IDLE_LEVEL;
      prev_reg <= esm_pkg::PIN_IDLE_LEVEL;
    end else begin
      meta_reg <= PIN_N;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge detect works only on settled stages
  assign pin.level_low = ~sync_reg;
  assign pin.fall = prev_reg & ~sync_reg;

endmodule : esm_pin_sync

// file: tb/esm_unit_asserts.sv
// Purpose: Port level assertions for the unit.
// Assumes: One clock, async active high reset.
// Notes:   Bound at the foot of this file.
`timescale 1ns/1ps

module esm_unit_asserts (
  // Clock and reset
  input logic CLK,
  SYS_RST,
  // Exception request and result (all inputs)
  EXC_REQ,
  esm_pkg::esm_cause_t EXC_CAUSE,
  logic REAL_MODE,
  logic [12:0] EXC_SEL_INDEX,
  logic EXC_SEL_TABLE_INDICATOR,
  EXC_IN_HANDLER,
  PF_PROT_VIOLATION,
  PF_WRITE,
  PF_USER,
  EXC_VALID,
  EXC_DROPPED,
  logic [7:0] EXC_VECTOR,
  logic EXC_ERR_PUSH,
  logic [15:0] EXC_ERR_CODE,
  // Management triggers and configuration
  logic SYSMGMT_IRQ_N,
  SW_SYSMGMT_TRIGGER_INSTR,
  MEM_REGION_TRIGGER,
  logic [31:0] SYSMGMT_REGION_BASE,
  SYSMGMT_REGION_SIZE,
  logic SYSMGMT_ACCESS_CTRL,
  SYSMGMT_PIN_ENABLE,
  // Entry results
  NMI_TAKE,
  logic [31:0] SAVE_DBG7,
  logic HDR_WE,
  logic [31:0] HDR_ADDR,
  HDR_DATA,
  logic FETCH_VALID,
  logic [31:0] FETCH_ADDR,
  logic FORCE_REAL_MODE,
  SYSMGMT_MODE,
  SYSMGMT_PENDING
);
  logic rm_req;
  logic pm_req;
  logic set_ok;

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Request qualifiers shared by several properties
  assign rm_req = EXC_REQ && REAL_MODE;
  assign pm_req = EXC_REQ && !REAL_MODE;
  assign set_ok = |SYSMGMT_REGION_SIZE;

  // --------------------------------------
  // Exception vectors and error codes
  // --------------------------------------
  a_real_no_vec: assert property (rm_req && EXC_CAUSE inside {esm_pkg::CAUSE_BAD_TASK_SEG,
    esm_pkg::CAUSE_NOT_PRESENT, esm_pkg::CAUSE_PAGE} |=> EXC_DROPPED && !EXC_VALID) else $error("vector raised");
  a_real_table_vec: assert property (rm_req && EXC_CAUSE == esm_pkg::CAUSE_IDT_LIMIT |=> EXC_VECTOR == 8'h08)
    else $error("table vector");
  a_real_stack_vec: assert property (rm_req && EXC_CAUSE == esm_pkg::CAUSE_STACK_LIMIT |=> EXC_VECTOR == 8'h0c)
    else $error("stack vector");
  a_gp_push_mode: assert property (EXC_REQ && EXC_CAUSE == esm_pkg::CAUSE_GEN_PROT |=>
    EXC_VECTOR == 8'h0d && EXC_ERR_PUSH == !$past(REAL_MODE)) else $error("gp push");
  a_zero_code: assert property (pm_req && EXC_CAUSE inside {esm_pkg::CAUSE_DOUBLE, esm_pkg::CAUSE_ALIGN} |=>
    EXC_ERR_PUSH && EXC_ERR_CODE == 16'h0) else $error("code not zero");
  a_page_bits: assert property (pm_req && EXC_CAUSE == esm_pkg::CAUSE_PAGE |=>
    EXC_ERR_CODE[2:0] == {$past(PF_PROT_VIOLATION), $past(PF_WRITE), $past(PF_USER)}) else $error("page bits wrong");
  a_table_code: assert property (pm_req && EXC_CAUSE == esm_pkg::CAUSE_IDT_LIMIT |=>
    EXC_ERR_CODE[15:3] == $past(EXC_SEL_INDEX) && EXC_ERR_CODE[1:0] == {1'b1, $past(EXC_IN_HANDLER)})
    else $error("table code");
  a_seg_code: assert property (pm_req && EXC_CAUSE == esm_pkg::CAUSE_NOT_PRESENT |=> EXC_ERR_CODE ==
    {$past(EXC_SEL_INDEX), $past(EXC_SEL_TABLE_INDICATOR), 1'b0, $past(EXC_IN_HANDLER)})
    else $error("segment code");

  // --------------------------------------
  // Management entry
  // --------------------------------------
  a_nmi_holdoff: assert property (NMI_TAKE |-> !SYSMGMT_PENDING && !HDR_WE && !SYSMGMT_MODE)
    else $error("nmi granted");
  a_sw_entry: assert property (SW_SYSMGMT_TRIGGER_INSTR && set_ok && SYSMGMT_ACCESS_CTRL |=> SYSMGMT_PENDING)
    else $error("instr missed");
  a_region_entry: assert property (MEM_REGION_TRIGGER && set_ok && SYSMGMT_PIN_ENABLE |=> SYSMGMT_PENDING)
    else $error("region missed");
  a_pending_cause: assert property ($rose(SYSMGMT_PENDING) |-> $past(set_ok))
    else $error("no region");
  a_hdr_to_fetch: assert property ($fell(HDR_WE) |=> FETCH_VALID && FETCH_ADDR == SYSMGMT_REGION_BASE &&
    FORCE_REAL_MODE) else $error("fetch wrong");
  a_hdr_first_word: assert property (HDR_WE && HDR_ADDR == SYSMGMT_REGION_BASE + SYSMGMT_REGION_SIZE -
    32'h4 |-> HDR_DATA == SAVE_DBG7) else $error("header word");
  a_pin_edge_entry: assert property ($fell(SYSMGMT_IRQ_N) && set_ok && SYSMGMT_PIN_ENABLE |->
    ##[2:4] SYSMGMT_PENDING) else $error("pin missed");

  // Main scenarios reached
  c_dropped: cover property (EXC_DROPPED);
  c_fetch: cover property (FETCH_VALID);
  c_pin_entry: cover property ($fell(SYSMGMT_IRQ_N) ##3 SYSMGMT_PENDING);
endmodule : esm_unit_asserts

bind esm_unit esm_unit_asserts esm_unit_asserts_i (.*);

// file: tb/esm_chipset_model.sv
// Purpose: Chipset model driving the management pin.
// Assumes: FIRE is high one cycle per event.
// Notes:   Pin idles high between events.
`timescale 1ns/1ps

module esm_chipset_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Event requests
  input wire logic FIRE,
  input wire logic SLOW,
  // Management pin, active low
  output logic SYSMGMT_IRQ_N
);
  int queued_reg;
  int cnt_reg;
  logic low_reg;

  // Queue events; each gets its own low pulse of three clocks or more
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      queued_reg <= 0;
      cnt_reg <= 0;
      low_reg <= 1'b0;
    end else begin
      queued_reg <= queued_reg + int'(FIRE);
      if (cnt_reg != 0) begin
        cnt_reg <= cnt_reg - 1;
      end else if (low_reg) begin
        low_reg <= 1'b0;
        cnt_reg <= 2;
      end else if (queued_reg + int'(FIRE) != 0) begin
        low_reg <= 1'b1;
        cnt_reg <= SLOW ? 6 : 2;
        queued_reg <= queued_reg + int'(FIRE) - 1;
      end
    end
  end

  // Off the edge, as the pin is asynchronous
  assign #1.3 SYSMGMT_IRQ_N = !low_reg;
endmodule : esm_chipset_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the unit.
// Assumes: Inputs change just after the rising edge.
// Notes:   Xorshift random values, fixed seed.
`timescale 1ns/1ps

module tb;
  logic CLK, SYS_RST, EXC_REQ, REAL_MODE, EXC_SEL_TABLE_INDICATOR, EXC_IN_HANDLER, PF_PROT_VIOLATION, PF_WRITE;
  logic PF_USER, EXC_VALID, EXC_DROPPED, EXC_ERR_PUSH, SYSMGMT_IRQ_N, SW_SYSMGMT_TRIGGER_INSTR, MEM_REGION_TRIGGER;
  logic RESUME_FROM_SYSMGMT, SYSMGMT_ACCESS_CTRL, SYSMGMT_PIN_ENABLE, NMI_REQ, NMI_TAKE, HDR_WE, HDR_READY;
  logic FETCH_VALID, FORCE_REAL_MODE, SYSMGMT_MODE, SYSMGMT_PENDING, fire, slow;
  esm_pkg::esm_cause_t EXC_CAUSE;
  logic [12:0] EXC_SEL_INDEX;
  logic [7:0] EXC_VECTOR;
  logic [15:0] EXC_ERR_CODE, SAVE_CS_SEL;
  logic [31:0] SYSMGMT_REGION_BASE, SYSMGMT_REGION_SIZE, SAVE_DBG7, SAVE_EFLAGS, SAVE_CTRL0, SAVE_CUR_IP;
  logic [31:0] SAVE_NEXT_IP, HDR_ADDR, HDR_DATA, FETCH_ADDR, seed, r;
  logic [63:0] SAVE_CS_DESC;
  logic [26:0] e, seen;
  int n_errors, samples_checked, cycles;

  esm_unit esm_unit_i (.*);
  esm_chipset_model esm_chipset_model_i (.CLK, .SYS_RST, .FIRE(fire), .SLOW(slow), .SYSMGMT_IRQ_N);

  // Clock of 5 ns
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // --------------------------------------
  // Helpers
  // --------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected {valid, dropped, vector, push, code}
  function automatic logic [26:0] exp_exc(esm_pkg::esm_cause_t c, logic rm);
    logic [15:0] seg;
    seg = {EXC_SEL_INDEX, EXC_SEL_TABLE_INDICATOR, 1'b0, EXC_IN_HANDLER};
    case (c)
      esm_pkg::CAUSE_DOUBLE: return {2'b10, 8'h08, !rm, 16'h0};
      esm_pkg::CAUSE_ALIGN: return {2'b10, 8'h11, !rm, 16'h0};
      esm_pkg::CAUSE_IDT_LIMIT: return rm ? {2'b10, 8'h08, 17'h0} :
        {2'b10, 8'h0d, 1'b1, EXC_SEL_INDEX, 2'b01, EXC_IN_HANDLER};
      esm_pkg::CAUSE_STACK_LIMIT: return {2'b10, 8'h0c, !rm, rm ? 16'h0 : seg};
      esm_pkg::CAUSE_BAD_TASK_SEG: return rm ? 27'h2000000 : {2'b10, 8'h0a, 1'b1, seg};
      esm_pkg::CAUSE_NOT_PRESENT: return rm ? 27'h2000000 : {2'b10, 8'h0b, 1'b1, seg};
      esm_pkg::CAUSE_PAGE: return rm ? 27'h2000000 :
        {2'b10, 8'h0e, 1'b1, 13'h0, PF_PROT_VIOLATION, PF_WRITE, PF_USER};
      default: return {2'b10, 8'h0d, !rm, rm ? 16'h0 : seg};
    endcase
  endfunction : exp_exc

  task automatic check(string what, logic [31:0] got, logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask : check

  // One clock; header port stalls a quarter of the time
  task automatic step();
    @(posedge CLK);
    #1;
    r = rnd();
    HDR_READY = r[1:0] != 2'b00;
    NMI_REQ = r[2];
    #0.1;
  endtask : step

  task automatic trig(ref logic s);
    {SAVE_DBG7, SAVE_EFLAGS, SAVE_CTRL0, SAVE_CUR_IP, SAVE_NEXT_IP} = {rnd(), rnd(), rnd(), rnd(), rnd()};
    SAVE_CS_DESC = {rnd(), rnd()};
    SAVE_CS_SEL = 16'(rnd());
    s = 1'b1;
    step();
    s = 1'b0;
  endtask : trig

  task automatic quiet(int n);
    repeat (n) begin
      step();
      check("idle", {SYSMGMT_PENDING, HDR_WE, NMI_TAKE}, {2'b00, NMI_REQ});
    end
  endtask : quiet

  // Follows one entry word by word, then resumes
  task automatic entry();
    logic [31:0] top;
    logic [31:0] hdr [8];
    int w;
    top = SYSMGMT_REGION_BASE + SYSMGMT_REGION_SIZE;
    hdr = '{SAVE_DBG7, SAVE_EFLAGS, SAVE_CTRL0, SAVE_CUR_IP, SAVE_NEXT_IP, {16'h0, SAVE_CS_SEL},
      SAVE_CS_DESC[63:32], SAVE_CS_DESC[31:0]};
    w = 0;
    for (int k = 0; k < 200 && FETCH_VALID !== 1'b1; k++) begin
      step();
      if (HDR_WE === 1'b1) check("nmi", NMI_TAKE, 0);
      if (HDR_WE === 1'b1 && HDR_READY && w < 8) begin
        check("hdr addr", HDR_ADDR, top - 32'(4 * (w + 1)));
        check("hdr data", HDR_DATA, hdr[w]);
        w++;
      end
    end
    check("words", w, 8);
    check("fetch", FETCH_ADDR, SYSMGMT_REGION_BASE);
    check("mode", {FETCH_VALID, FORCE_REAL_MODE, SYSMGMT_MODE}, 3'b111);
    RESUME_FROM_SYSMGMT = 1'b1;
    step();
    RESUME_FROM_SYSMGMT = 1'b0;
    check("resume", {FORCE_REAL_MODE, SYSMGMT_MODE}, 2'b00);
  endtask : entry

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard; the run needs under 1000 cycles
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // --------------------------------------
  // Main sequence
  // --------------------------------------
  initial begin
    seed = 32'h15aaf;
    {SYS_RST, slow} = 2'b11;
    {EXC_REQ, SW_SYSMGMT_TRIGGER_INSTR, MEM_REGION_TRIGGER, RESUME_FROM_SYSMGMT, fire, NMI_REQ, HDR_READY} = '0;
    {SYSMGMT_REGION_BASE, SYSMGMT_REGION_SIZE, SYSMGMT_ACCESS_CTRL, SYSMGMT_PIN_ENABLE} = '0;
    repeat (5) step();
    SYS_RST = 1'b0;
    // All causes in both modes, then random
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      EXC_REQ = 1'b1;
      EXC_CAUSE = esm_pkg::esm_cause_t'(4'(i < 18 ? i % 9 : r[7:0] % 9));
      REAL_MODE = i < 18 ? i >= 9 : r[8];
      {EXC_SEL_INDEX, EXC_SEL_TABLE_INDICATOR, EXC_IN_HANDLER, PF_PROT_VIOLATION, PF_WRITE, PF_USER} = r[31:14];
      e = exp_exc(EXC_CAUSE, REAL_MODE);
      step();
      seen = {EXC_VALID, EXC_DROPPED, EXC_VECTOR, EXC_ERR_PUSH, EXC_ERR_CODE};
      check("exception", e[25] ? {seen[26:25], 25'h0000000} : seen, e);
    end
    EXC_REQ = 1'b0;
    // Management entry from each source
    SYSMGMT_REGION_BASE = rnd() & 32'hffff_0000;
    SYSMGMT_REGION_SIZE = 32'h10000;
    {SYSMGMT_ACCESS_CTRL, SYSMGMT_PIN_ENABLE} = 2'b11;
    quiet(3);
    trig(SW_SYSMGMT_TRIGGER_INSTR);
    entry();
    trig(MEM_REGION_TRIGGER);
    entry();
    {SW_SYSMGMT_TRIGGER_INSTR, MEM_REGION_TRIGGER} = 2'b11;
    step();
    {SW_SYSMGMT_TRIGGER_INSTR, MEM_REGION_TRIGGER} = 2'b00;
    entry();
    quiet(10);
    trig(fire);
    entry();
    // Two events: second edge lands mid entry
    slow = 1'b0;
    fire = 1'b1;
    step();
    step();
    fire = 1'b0;
    entry();
    entry();
    quiet(10);
    // Unqualified triggers must be ignored
    SYSMGMT_REGION_SIZE = 32'h0;
    {SW_SYSMGMT_TRIGGER_INSTR, MEM_REGION_TRIGGER, fire} = 3'b111;
    step();
    {SW_SYSMGMT_TRIGGER_INSTR, MEM_REGION_TRIGGER, fire} = 3'b000;
    quiet(20);
    {SYSMGMT_REGION_SIZE, SYSMGMT_ACCESS_CTRL} = {32'h1000, 1'b0};
    trig(SW_SYSMGMT_TRIGGER_INSTR);
    quiet(5);
    {SYSMGMT_ACCESS_CTRL, SYSMGMT_PIN_ENABLE, MEM_REGION_TRIGGER, fire} = 4'b1011;
    step();
    {MEM_REGION_TRIGGER, fire} = 2'b00;
    quiet(20);
    tally_and_finish();
  end
endmodule : tb
